//--- core/tcc_timer.v
// 16-bit timer/counter with capture, auto-reload and baud clock modes.
// Assumes count and trigger pins are synchronous to clk_i; one clock is one oscillator period.
//
// Our own choice: the Avalon-MM interface to the registers.
`timescale 1ns/100ps
`include "tcc_defs.vh"

module tcc_timer #(
  parameter MACHINE_CLOCKS = `TCC_MACHINE_CLOCKS,
  parameter STATE_CLOCKS   = `TCC_STATE_CLOCKS
) (
  input  wire        clk_i,
  input  wire        rst_b_i,
  input  wire [7:0]  avs_address_i,
  input  wire        avs_read_i,
  input  wire        avs_write_i,
  input  wire [31:0] avs_writedata_i,
  input  wire [3:0]  avs_byteenable_i,
  output reg  [31:0] avs_readdata_o,
  output reg         avs_waitrequest_o,
  input  wire        count_input_pin_i,
  input  wire        ext_trigger_pin_i,
  input  wire        timer_int_enable_i,
  input  wire        other_timer_ovf_i,
  output reg         timer_irq_o,
  output reg         rx_clock_o,
  output reg         tx_clock_o
);

  localparam MODE_OFF     = 2'h0;
  localparam MODE_RELOAD  = 2'h1;
  localparam MODE_CAPTURE = 2'h2;
  localparam MODE_BAUD    = 2'h3;

  // Prescaler widths fit the default counts; widen them with the counts
  localparam MACHINE_WIDTH = 4;
  localparam STATE_WIDTH   = 2;

  reg  [7:0]  timer_control_reg;
  reg  [7:0]  timer_mode_reg;
  reg  [15:0] count;
  reg  [15:0] capture_reload;

  reg  [7:0]  next_control;
  reg  [15:0] next_count;
  reg  [15:0] next_capture_reload;
  reg  [1:0]  mode;
  reg  [31:0] read_word;

  wire        overflow_flag         = timer_control_reg[`TCC_BIT_OVF];
  wire        external_flag         = timer_control_reg[`TCC_BIT_EXT];
  wire        rx_clock_select       = timer_control_reg[`TCC_BIT_RCLK];
  wire        tx_clock_select       = timer_control_reg[`TCC_BIT_TX_CLOCK_SELECT];
  wire        ext_trigger_enable    = timer_control_reg[`TCC_BIT_EXEN];
  wire        run_control           = timer_control_reg[`TCC_BIT_RUN];
  wire        counter_select        = timer_control_reg[`TCC_BIT_CNT];
  wire        capture_reload_select = timer_control_reg[`TCC_BIT_CPRL];
  wire        down_count_enable     = timer_mode_reg[`TCC_BIT_DOWN_COUNT_ENABLE];
  wire        serial_clocking       = rx_clock_select | tx_clock_select;

  wire        bus_req   = avs_read_i | avs_write_i;
  wire        bus_done  = bus_req & ~avs_waitrequest_o;
  wire        wr_low    = avs_write_i & bus_done & avs_byteenable_i[0];
  wire        wr_ctrl   = wr_low & (avs_address_i == `TCC_ADDR_CONTROL);
  wire        wr_mode   = wr_low & (avs_address_i == `TCC_ADDR_MODE);
  wire        wr_cnt_l  = wr_low & (avs_address_i == `TCC_ADDR_COUNT_LOW);
  wire        wr_cnt_h  = wr_low & (avs_address_i == `TCC_ADDR_COUNT_HIGH);
  wire        wr_cap_l  = wr_low & (avs_address_i == `TCC_ADDR_CAP_LOW);
  wire        wr_cap_h  = wr_low & (avs_address_i == `TCC_ADDR_CAP_HIGH);

  wire        machine_tick;
  wire        state_tick;
  wire        count_fall;
  wire        trig_fall;

  reg         tick;
  reg         overflow_ev;
  reg         trig_ev;
  reg         do_capture;
  reg         do_reload;

  // Mode selection from the control bits
  // Serial clocking outranks capture so the baud rate never stalls on a capture
  always @* begin
    if (!run_control) begin
      mode = MODE_OFF;
    end else if (serial_clocking) begin
      mode = MODE_BAUD;
    end else if (capture_reload_select) begin
      mode = MODE_CAPTURE;
    end else begin
      mode = MODE_RELOAD;
    end
  end

  // Count events and their consequences
  always @* begin
    tick        = 1'b0;
    overflow_ev = 1'b0;
    trig_ev     = 1'b0;
    do_capture  = 1'b0;
    do_reload   = 1'b0;
    case (mode)
      MODE_OFF: begin
        tick = 1'b0;
      end
      MODE_BAUD: begin
        // Baud generation runs at the state rate, six times the machine rate
        tick = counter_select ? count_fall : state_tick;
      end
      default: begin
        tick = counter_select ? count_fall : machine_tick;
      end
    endcase
    // Overflow is the tick that finds the count at its top value
    overflow_ev = tick & (count == `TCC_COUNT_MAX);
    // Trigger edges are ignored while the timer clocks the serial port
    // Captures and reloads from the pin still act while run_control is 0
    trig_ev = trig_fall & ext_trigger_enable & ~serial_clocking;
    if (serial_clocking) begin
      do_reload = overflow_ev;
    end else if (capture_reload_select) begin
      do_capture = trig_ev;
    end else begin
      do_reload = overflow_ev | trig_ev;
    end
  end

  // Next count, capture register and control value
  always @* begin
    next_count          = count;
    next_capture_reload = capture_reload;
    next_control        = timer_control_reg;
    if (do_reload) begin
      next_count = capture_reload;
    end else if (tick) begin
      next_count = count + 16'h0001;
    end
    if (do_capture) begin
      next_capture_reload = count;
    end
    // Software writes to the count or capture bytes take priority over hardware
    if (wr_cnt_l) begin
      next_count[7:0] = avs_writedata_i[7:0];
    end
    if (wr_cnt_h) begin
      next_count[15:8] = avs_writedata_i[7:0];
    end
    if (wr_cap_l) begin
      next_capture_reload[7:0] = avs_writedata_i[7:0];
    end
    if (wr_cap_h) begin
      next_capture_reload[15:8] = avs_writedata_i[7:0];
    end
    if (wr_ctrl) begin
      next_control = avs_writedata_i[7:0];
    end
    // Flags never clear by hardware; a set in the cycle of a clear still lands
    if (overflow_ev && !serial_clocking) begin
      next_control[`TCC_BIT_OVF] = 1'b1;
    end
    if (trig_ev) begin
      next_control[`TCC_BIT_EXT] = 1'b1;
    end
  end

  // Read mux; unmapped addresses read as zero
  // Count halves are read apart; software must guard against a carry between them
  always @* begin
    read_word = 32'h00000000;
    case (avs_address_i)
      `TCC_ADDR_CONTROL: begin
        read_word[7:0] = timer_control_reg;
      end
      `TCC_ADDR_MODE: begin
        read_word[7:0] = timer_mode_reg;
      end
      `TCC_ADDR_COUNT_LOW: begin
        read_word[7:0] = count[7:0];
      end
      `TCC_ADDR_COUNT_HIGH: begin
        read_word[7:0] = count[15:8];
      end
      `TCC_ADDR_CAP_LOW: begin
        read_word[7:0] = capture_reload[7:0];
      end
      `TCC_ADDR_CAP_HIGH: begin
        read_word[7:0] = capture_reload[15:8];
      end
      default: begin
        read_word = 32'h00000000;
      end
    endcase
  end

  // Prescalers run free from reset, so the first machine tick is the twelfth edge
  tcc_divider #(
    .WIDTH (MACHINE_WIDTH),
    .COUNT (MACHINE_CLOCKS)
  ) machine_divider_i (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (machine_tick)
  );

  tcc_divider #(
    .WIDTH (STATE_WIDTH),
    .COUNT (STATE_CLOCKS)
  ) state_divider_i (
    .clk_i   (clk_i),
    .rst_b_i (rst_b_i),
    .tick_o  (state_tick)
  );

  // One sample per machine cycle; a level shorter than that may be missed
  tcc_fall_detect count_edge_i (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .sample_en_i (machine_tick),
    .pin_i       (count_input_pin_i),
    .fall_o      (count_fall)
  );

  tcc_fall_detect trig_edge_i (
    .clk_i       (clk_i),
    .rst_b_i     (rst_b_i),
    .sample_en_i (machine_tick),
    .pin_i       (ext_trigger_pin_i),
    .fall_o      (trig_fall)
  );

  // Timer state
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_control_reg <= `TCC_RST_CONTROL;
      timer_mode_reg    <= `TCC_RST_MODE;
      count             <= `TCC_RST_COUNT;
      capture_reload    <= `TCC_RST_COUNT;
    end else begin
      timer_control_reg <= next_control;
      count             <= next_count;
      capture_reload    <= next_capture_reload;
      // Only the down-count enable is kept; it masks the external flag interrupt
      if (wr_mode) begin
        timer_mode_reg <= {7'h00, avs_writedata_i[`TCC_BIT_DOWN_COUNT_ENABLE]};
      end
    end
  end

  // Interrupt request and serial clocks, registered
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      timer_irq_o <= 1'b0;
      rx_clock_o  <= 1'b0;
      tx_clock_o  <= 1'b0;
    end else begin
      timer_irq_o <= timer_int_enable_i &
                     (overflow_flag | (external_flag & ~down_count_enable));
      rx_clock_o  <= rx_clock_select ? overflow_ev : other_timer_ovf_i;
      tx_clock_o  <= tx_clock_select ? overflow_ev : other_timer_ovf_i;
    end
  end

  // Bus slave: one wait cycle per access
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_waitrequest_o <= 1'b1;
    end else if (bus_req && avs_waitrequest_o) begin
      avs_waitrequest_o <= 1'b0;
    end else begin
      avs_waitrequest_o <= 1'b1;
    end
  end

  // Read data latched as the wait is released and held until the next read
  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      avs_readdata_o <= 32'h00000000;
    end else if (avs_read_i && avs_waitrequest_o) begin
      avs_readdata_o <= read_word;
    end
  end

endmodule

// Free-running divider: one-clock tick every COUNT clocks
module tcc_divider #(
  parameter WIDTH = 4,
  parameter COUNT = `TCC_MACHINE_CLOCKS
) (
  input  wire clk_i,
  input  wire rst_b_i,
  output wire tick_o
);

  // Sized copy so the compare stays at the counter width
  localparam [31:0] LAST = COUNT - 1;

  reg  [WIDTH-1:0] div;
  wire             at_last = (div == LAST[WIDTH-1:0]);

  // Tick is combinational; whatever leaves the block is registered by the caller
  assign tick_o = at_last;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      div <= {WIDTH{1'b0}};
    end else if (at_last) begin
      div <= {WIDTH{1'b0}};
    end else begin
      div <= div + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

endmodule

// Samples a pin when enabled and flags a high sample followed by a low one
// Detection lags the pin by one to two sample periods
module tcc_fall_detect (
  input  wire clk_i,
  input  wire rst_b_i,
  input  wire sample_en_i,
  input  wire pin_i,
  output wire fall_o
);

  reg sample;
  reg sample_prev;

  // Both stages clear on reset; a pin idling high then shows a rise, never a false fall
  assign fall_o = sample_en_i & sample_prev & ~sample;

  always @(posedge clk_i) begin
    if (!rst_b_i) begin
      sample      <= 1'b0;
      sample_prev <= 1'b0;
    end else if (sample_en_i) begin
      sample      <= pin_i;
      sample_prev <= sample;
    end
  end

endmodule

//--- core/tcc_defs.vh
// Constants for the timer/counter with control register and capture mode.
// Assumes a byte-addressed Avalon-MM slave with 32-bit data; registers use the low byte.
`ifndef TCC_DEFS_VH
`define TCC_DEFS_VH

`define TCC_ADDR_CONTROL      8'hc8
`define TCC_ADDR_MODE         8'hcc
`define TCC_ADDR_COUNT_LOW    8'hd0
`define TCC_ADDR_COUNT_HIGH   8'hd4
`define TCC_ADDR_CAP_LOW      8'hd8
`define TCC_ADDR_CAP_HIGH     8'hdc

`define TCC_BIT_OVF           7
`define TCC_BIT_EXT           6
`define TCC_BIT_RCLK          5
`define TCC_BIT_TX_CLOCK_SELECT          4
`define TCC_BIT_EXEN          3
`define TCC_BIT_RUN           2
`define TCC_BIT_CNT           1
`define TCC_BIT_CPRL          0
`define TCC_BIT_DOWN_COUNT_ENABLE          0

`define TCC_RST_CONTROL       8'h00
`define TCC_RST_MODE          8'h00
`define TCC_RST_COUNT         16'h0000
`define TCC_COUNT_MAX         16'hffff

`define TCC_MACHINE_CLOCKS    12
`define TCC_STATE_CLOCKS      2

`endif

//--- tb/tcc_timer_monitor.sv
// Checker for the tcc_timer register bus, interrupt and serial clock outputs.
// Sees only the top ports; shadows the software-only control bits from bus writes.
`timescale 1ns/100ps
module tcc_timer_monitor (
  input wire        clk_i,
  input wire        rst_b_i,
  input wire [7:0]  avs_address_i,
  input wire        avs_read_i,
  input wire        avs_write_i,
  input wire [31:0] avs_writedata_i,
  input wire [3:0]  avs_byteenable_i,
  input wire [31:0] avs_readdata_o,
  input wire        avs_waitrequest_o,
  input wire        timer_int_enable_i,
  input wire        other_timer_ovf_i,
  input wire        timer_irq_o,
  input wire        rx_clock_o,
  input wire        tx_clock_o
);
  reg  [5:0] sw_bits;
  wire       taken = avs_waitrequest_o && avs_read_i;
  wire       unmapped = avs_address_i[1:0] != 2'h0 || avs_address_i[7:2] < 6'h32
                        || avs_address_i[7:2] > 6'h37;
  // Hardware never alters these bits, so a shadow of the writes predicts them
  always @(posedge clk_i) begin
    if (!rst_b_i)
      sw_bits <= 6'h00;
    else if (avs_write_i && !avs_waitrequest_o && avs_byteenable_i[0] && avs_address_i == 8'hc8)
      sw_bits <= avs_writedata_i[5:0];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  property p_wait_one;
    !avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("wait low longer than one cycle");
  property p_take;
    (avs_read_i || avs_write_i) && avs_waitrequest_o |=> !avs_waitrequest_o;
  endproperty
  a_take: assert property (p_take) else $error("request not answered next cycle");
  property p_idle;
    !avs_read_i && !avs_write_i && avs_waitrequest_o |=> avs_waitrequest_o;
  endproperty
  a_idle: assert property (p_idle) else $error("wait dropped with no request");
  property p_unmapped;
    taken && unmapped |=> avs_readdata_o == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_ctl_read;
    taken && avs_address_i == 8'hc8 |=> avs_readdata_o[31:8] == 24'h0
      && avs_readdata_o[5:0] == sw_bits;
  endproperty
  a_ctl_read: assert property (p_ctl_read) else $error("control read mismatch");
  property p_irq_en;
    !timer_int_enable_i |=> !timer_irq_o;
  endproperty
  a_irq_en: assert property (p_irq_en) else $error("irq without enable");
  property p_rx_pass;
    $past(rst_b_i) && !sw_bits[5] |=> rx_clock_o == $past(other_timer_ovf_i);
  endproperty
  a_rx_pass: assert property (p_rx_pass) else $error("rx clock not other timer");
  property p_tx_pass;
    $past(rst_b_i) && !sw_bits[4] |=> tx_clock_o == $past(other_timer_ovf_i);
  endproperty
  a_tx_pass: assert property (p_tx_pass) else $error("tx clock not other timer");
endmodule
bind tcc_timer tcc_timer_monitor tcc_timer_monitor_i (.clk_i(clk_i), .rst_b_i(rst_b_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .timer_int_enable_i(timer_int_enable_i), .other_timer_ovf_i(other_timer_ovf_i),
  .timer_irq_o(timer_irq_o), .rx_clock_o(rx_clock_o), .tx_clock_o(tx_clock_o));

//--- tb/tcc_pin_model.sv
// Model of the external count source and trigger source.
// One request gives one falling edge; requests while busy are dropped.
`timescale 1ns/100ps
module tcc_pin_model (
  input  wire clk_i,
  input  wire count_req_i,
  input  wire trig_req_i,
  output wire count_input_pin_o,
  output wire ext_trigger_pin_o
);
  reg [5:0] count_hold = 6'h00;
  reg [5:0] trig_hold = 6'h00;
  // Low for 24 clocks, then high 24 more, so each level spans two machine cycles
  assign count_input_pin_o = !(count_hold > 6'h18);
  assign ext_trigger_pin_o = !(trig_hold > 6'h18);
  always @(posedge clk_i) begin
    if (count_hold != 6'h00)
      count_hold <= count_hold - 6'h01;
    else if (count_req_i)
      count_hold <= 6'h30;
    if (trig_hold != 6'h00)
      trig_hold <= trig_hold - 6'h01;
    else if (trig_req_i)
      trig_hold <= 6'h30;
  end
endmodule

//--- tb/timer2_control_capture_tb_top.sv
// Self-checking bench for tcc_timer with random reload values and pin model.
// Assumes one wait cycle per bus access and flags that hold until written.
`timescale 1ns/100ps
module timer2_control_capture_tb_top;
  reg         clk_i = 1'b0;
  reg         rst_b_i = 1'b0;
  reg  [7:0]  addr = 8'h00;
  reg         rd = 1'b0;
  reg         wr = 1'b0;
  reg  [31:0] wdata = 32'h0;
  reg         int_en = 1'b0;
  reg         other_ovf = 1'b0;
  reg         count_req = 1'b0;
  reg         trig_req = 1'b0;
  reg  [3:0]  be = 4'hf;
  wire [31:0] rdata;
  wire        waitreq, irq, rx_clk, tx_clk, count_pin, trig_pin;
  integer     err_count = 0;
  integer     comparisons = 0;
  integer     seed = 50;
  integer     pulses = 0;
  integer     rx_pulses = 0;
  integer     p0;
  reg  [31:0] val;
  reg  [15:0] rv;
  reg  [15:0] cnt;
  always #20 clk_i = ~clk_i;
  always @(posedge clk_i) other_ovf <= ($random(seed) % 4) == 0;
  always @(posedge clk_i) if (tx_clk === 1'b1) pulses <= pulses + 1;
  always @(posedge clk_i) if (rx_clk === 1'b1) rx_pulses <= rx_pulses + 1;
  tcc_timer tcc_timer_i (.clk_i(clk_i), .rst_b_i(rst_b_i), .avs_address_i(addr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
    .avs_readdata_o(rdata), .avs_waitrequest_o(waitreq), .count_input_pin_i(count_pin),
    .ext_trigger_pin_i(trig_pin), .timer_int_enable_i(int_en), .other_timer_ovf_i(other_ovf),
    .timer_irq_o(irq), .rx_clock_o(rx_clk), .tx_clock_o(tx_clk));
  tcc_pin_model tcc_pin_model_i (.clk_i(clk_i), .count_req_i(count_req), .trig_req_i(trig_req),
    .count_input_pin_o(count_pin), .ext_trigger_pin_o(trig_pin));
  task complete_run;
    begin
      $display("Comparisons %0d, mismatches %0d", comparisons, err_count);
      if (err_count == 0 && comparisons > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
    end
  endtask
  task check(input string name, input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp) begin
        err_count = err_count + 1;
        $display("BAD %0s expected %h seen %h", name, exp, seen);
      end
    end
  endtask
  // Holds the request until waitrequest is sampled low; read data taken at that edge
  task bus(input w, input [7:0] a, input [31:0] d);
    integer n;
    begin
      @(posedge clk_i);
      rd <= !w; wr <= w; addr <= a; wdata <= d;
      n = 0;
      @(posedge clk_i);
      while (waitreq !== 1'b0 && n < 20) begin
        @(posedge clk_i);
        n = n + 1;
      end
      if (n == 20) begin
        err_count = err_count + 1;
        complete_run;
      end
      val = rdata;
      rd <= 1'b0; wr <= 1'b0;
    end
  endtask
  task pin(input c);
    begin
      if (c) count_req <= 1'b1; else trig_req <= 1'b1;
      @(posedge clk_i);
      count_req <= 1'b0; trig_req <= 1'b0;
      repeat (50) @(posedge clk_i);
    end
  endtask
  task wr16(input [7:0] a, input [15:0] v);
    begin
      bus(1, a, {24'h0, v[7:0]});
      bus(1, a + 8'h04, {24'h0, v[15:8]});
    end
  endtask
  initial begin
    repeat (6) @(posedge clk_i);
    rst_b_i <= 1'b1;
    bus(0, 8'hc8, 0); check("control reset", val, 32'h0);
    bus(0, 8'he0, 0); check("unmapped read", val, 32'h0);
    rv = $random(seed);
    rv[15] = 1'b1;
    // Keeps the reloaded count far from a second overflow during the rate checks
    rv[14] = 1'b0;
    wr16(8'hd8, rv); wr16(8'hd0, 16'hfffe);
    bus(1, 8'hc8, 32'h04);
    repeat (40) @(posedge clk_i);
    bus(0, 8'hc8, 0); check("overflow flag", val, 32'h84);
    bus(1, 8'hc8, 32'h80);
    bus(0, 8'hd0, 0); cnt[7:0] = val[7:0];
    bus(0, 8'hd4, 0); cnt[15:8] = val[7:0];
    check("reload value", {31'h0, cnt - rv < 16'd16}, 32'h1);
    repeat (60) @(posedge clk_i);
    bus(0, 8'hd0, 0); check("frozen count", val, {24'h0, cnt[7:0]});
    bus(1, 8'hc8, 32'h04);
    bus(0, 8'hd0, 0); cnt[7:0] = val[7:0];
    repeat (120) @(posedge clk_i);
    bus(0, 8'hd0, 0); cnt[15:8] = val[7:0] - cnt[7:0];
    check("tick rate", {31'h0, cnt[15:8] == 8'h0a || cnt[15:8] == 8'h0b}, 32'h1);
    int_en <= 1'b1;
    wr16(8'hd0, 16'h1234); bus(1, 8'hc8, 32'h0d);
    pin(0);
    bus(0, 8'hc8, 0); check("capture flag", val, 32'h4d);
    bus(0, 8'hdc, 0); check("captured high", val, 32'h12);
    check("irq set", {31'h0, irq}, 32'h1);
    bus(1, 8'hcc, 32'h01); repeat (2) @(posedge clk_i);
    check("irq masked", {31'h0, irq}, 32'h0);
    bus(1, 8'hcc, 32'h00); repeat (2) @(posedge clk_i);
    check("irq again", {31'h0, irq}, 32'h1);
    bus(1, 8'hc8, 32'h05); pin(0);
    bus(0, 8'hc8, 0); check("trigger ignored", val, 32'h05);
    be <= 4'he;
    bus(1, 8'hc8, 32'h00);
    be <= 4'hf;
    bus(0, 8'hc8, 0);
    check("masked write", val, 32'h05);
    rv = $random(seed);
    wr16(8'hd8, rv); wr16(8'hd0, 16'h0000); bus(1, 8'hc8, 32'h08);
    pin(0);
    bus(0, 8'hd0, 0); check("trigger reload low", val, {24'h0, rv[7:0]});
    bus(0, 8'hd4, 0); check("trigger reload high", val, {24'h0, rv[15:8]});
    bus(0, 8'hc8, 0); check("reload flag", val, 32'h48);
    bus(1, 8'hc8, 32'h06); wr16(8'hd0, 16'h0000);
    repeat (3) pin(1);
    bus(0, 8'hd0, 0); check("event count", val, 32'h03);
    wr16(8'hd8, 16'hfff0); wr16(8'hd0, 16'hfff0); bus(1, 8'hc8, 32'h15);
    // Two edges pass so that pulses still taken from the other timer are not counted
    repeat (2) @(posedge clk_i);
    p0 = pulses;
    repeat (200) @(posedge clk_i);
    check("baud pulses", {31'h0, pulses - p0 >= 5 && pulses - p0 <= 7}, 32'h1);
    bus(0, 8'hc8, 0); check("no flag in baud", val, 32'h15);
    bus(1, 8'hc8, 32'h25);
    repeat (2) @(posedge clk_i);
    p0 = rx_pulses;
    repeat (200) @(posedge clk_i);
    check("rx baud pulses", {31'h0, rx_pulses - p0 >= 5 && rx_pulses - p0 <= 7}, 32'h1);
    complete_run;
  end
endmodule
